// ### core/rxs_stat_counters.sv
`timescale 1ns/1ps
// Contract
// - Read returns count, then counter clears
// - Counter saturates at all ones
// - Count frames stored in packet buffer
// - Counter updated within one microsecond
// - Interrupt may precede counter update
// - Count filtered bad-check frames, 64+ bytes
// - No counting while reception disabled
// - Alignment errors also count as bad-check
// - 32-bit counter at 4000h, resets zero
// - Alignment valid only in slow MII
module rxs_stat_counters #(
  parameter int MIN_LEN = rxs_pkg::MIN_FRAME_BYTES,
  // Narrower counters only to reach saturation in short tests
  parameter int CNT_W = rxs_pkg::CNT_W
) (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Receive MAC frame report
  input wire rxs_pkg::rxs_frame_t frame_in
);

  initial begin
    if (MIN_LEN < 1 || MIN_LEN >= (1 << rxs_pkg::LEN_W)) begin
      $error("MIN_LEN out of range");
    end
    if (CNT_W < 1 || CNT_W > 32) begin
      $error("CNT_W out of range");
    end
    if (rxs_pkg::UPDATE_USED_CYC > rxs_pkg::UPDATE_LIMIT_CYC) begin
      $error("Update path slower than the bound");
    end
  end

  localparam logic [rxs_pkg::LEN_W-1:0] MIN_LEN_V = rxs_pkg::LEN_W'(MIN_LEN);
  // Counter constants cut to the counter width; all ones stays all ones
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(rxs_pkg::CNT_RESET);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(32'h0000_0001);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(rxs_pkg::CNT_MAX);

  // Zero-extend a counter onto the data bus
  function automatic logic [31:0] widen(input logic [CNT_W-1:0] c);
    widen = 32'(c);
  endfunction : widen

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] off);
    addr_is = (a[rxs_pkg::ADDR_HI:rxs_pkg::ADDR_LO] == off[rxs_pkg::ADDR_HI:rxs_pkg::ADDR_LO]);
  endfunction : addr_is

  // Next count: clearing read, event, saturation
  function automatic logic [CNT_W-1:0] next_count(input logic [CNT_W-1:0] cur,
                                                  input logic clr, input logic hit);
    if (clr) begin
      next_count = hit ? CNT_ONE : CNT_ZERO;
    end else if (hit && cur != CNT_TOP) begin
      next_count = cur + CNT_ONE;
    end else begin
      next_count = cur;
    end
  endfunction : next_count

  // Bus state
  logic [31:0] hrdata_q, hrdata_d;
  logic wr_pend_q, wr_pend_d;
  logic [31:0] wr_addr_q, wr_addr_d;
  logic [rxs_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  // Counter state
  rxs_pkg::rxs_hits_t hits_q, hits_d;
  logic [CNT_W-1:0] bad_fcs_q, bad_fcs_d;
  logic [CNT_W-1:0] misalign_q, misalign_d;

  logic addr_phase;
  logic rd_bad_fcs;
  logic rd_misalign;
  logic frame_ok;
  logic rx_en;
  logic mii_slow;

  assign rx_en = ctrl_q[rxs_pkg::CTRL_RX_EN_BIT];
  assign mii_slow = ctrl_q[rxs_pkg::CTRL_MII_SLOW_BIT];
  assign addr_phase = hsel_in && hready_in && (htrans_in == rxs_pkg::HTRANS_NONSEQ);
  assign rd_bad_fcs = addr_phase && !hwrite_in && addr_is(haddr_in, rxs_pkg::BAD_FCS_OFF);
  assign rd_misalign = addr_phase && !hwrite_in && addr_is(haddr_in, rxs_pkg::MISALIGN_OFF);
  // Stored in buffer, passed filters, long enough, while enabled
  assign frame_ok = frame_in.valid && frame_in.addr_pass && frame_in.stored
                    && (frame_in.len >= MIN_LEN_V) && rx_en;

  // Bus slave: zero wait states, read data latched at the address edge
  always_comb begin
    hrdata_d = hrdata_q;
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    ctrl_d = ctrl_q;
    if (wr_pend_q && addr_is(wr_addr_q, rxs_pkg::RX_CTRL_OFF)) begin
      ctrl_d = hwdata_in[rxs_pkg::CTRL_W-1:0];
    end
    if (addr_phase) begin
      wr_pend_d = hwrite_in;
      wr_addr_d = haddr_in;
      hrdata_d = 32'h0000_0000;
      if (!hwrite_in) begin
        if (rd_bad_fcs) begin
          hrdata_d = widen(bad_fcs_q);
        end else if (rd_misalign) begin
          hrdata_d = widen(misalign_q);
        end else if (addr_is(haddr_in, rxs_pkg::RX_CTRL_OFF)) begin
          hrdata_d = {{(32 - rxs_pkg::CTRL_W){1'b0}}, ctrl_q};
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hrdata_q <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      ctrl_q <= rxs_pkg::CTRL_RESET;
    end else if (ce_in) begin
      hrdata_q <= hrdata_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign hrdata_out = hrdata_q;
  // Never stalls and never errors, so both answers are constant flops
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= rxs_pkg::HRESP_OKAY;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= rxs_pkg::HRESP_OKAY;
    end
  end

  // Counters: one stage to qualify, one to add; far inside the bound
  always_comb begin
    hits_d.bad_fcs = frame_ok && (frame_in.fcs_bad || frame_in.align_err);
    hits_d.misalign = frame_ok && frame_in.align_err && mii_slow;
    bad_fcs_d = next_count(bad_fcs_q, rd_bad_fcs, hits_q.bad_fcs);
    misalign_d = next_count(misalign_q, rd_misalign, hits_q.misalign);
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hits_q <= '0;
      bad_fcs_q <= CNT_ZERO;
      misalign_q <= CNT_ZERO;
    end else if (ce_in) begin
      hits_q <= hits_d;
      bad_fcs_q <= bad_fcs_d;
      misalign_q <= misalign_d;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_read_clears: assert property (
    ce_in && rd_bad_fcs && !hits_q.bad_fcs |=> bad_fcs_q == CNT_ZERO
      && hrdata_out == widen($past(bad_fcs_q)))
    else $error("Counter read did not return and clear");

  a_sat_hold: assert property (
    bad_fcs_q == CNT_TOP && !rd_bad_fcs |=> bad_fcs_q == CNT_TOP)
    else $error("Saturated counter moved");

  a_stored_only: assert property (
    ce_in && frame_in.valid && !frame_in.stored |=> !hits_q.bad_fcs)
    else $error("Unstored frame counted");

  a_update_bound: assert property (
    (ce_in && frame_ok && frame_in.fcs_bad) ##1 (ce_in && !rd_bad_fcs)
      |=> bad_fcs_q != CNT_ZERO)
    else $error("Counter not updated in time");

  a_misalign_bound: assert property (
    (ce_in && frame_ok && frame_in.align_err && mii_slow) ##1 (ce_in && !rd_misalign)
      |=> misalign_q != CNT_ZERO)
    else $error("Misaligned counter not updated in time");

  a_count_step: assert property (
    ce_in && hits_q.bad_fcs && !rd_bad_fcs && bad_fcs_q != CNT_TOP
      |=> bad_fcs_q == $past(bad_fcs_q) + CNT_ONE)
    else $error("Counter did not step by one");

  a_no_spurious: assert property (
    ce_in && !hits_q.bad_fcs && !rd_bad_fcs |=> bad_fcs_q == $past(bad_fcs_q))
    else $error("Counter moved without an event");

  a_bad_frame_hit: assert property (
    ce_in && frame_ok && frame_in.fcs_bad |=> hits_q.bad_fcs)
    else $error("Qualified bad frame not counted");

  a_good_frame: assert property (
    ce_in && frame_in.valid && !frame_in.fcs_bad && !frame_in.align_err
      |=> !hits_q.bad_fcs)
    else $error("Good frame counted");

  a_filter_pass: assert property (
    ce_in && !frame_in.addr_pass |=> !hits_q.bad_fcs)
    else $error("Filtered frame counted");

  a_short_frame: assert property (
    ce_in && frame_in.len < MIN_LEN_V |=> !hits_q.bad_fcs)
    else $error("Short frame counted");

  a_rx_disabled: assert property (
    ce_in && !rx_en |=> !hits_q.bad_fcs && !hits_q.misalign)
    else $error("Counted while reception disabled");

  a_ctrl_write: assert property (
    ce_in && wr_pend_q && addr_is(wr_addr_q, rxs_pkg::RX_CTRL_OFF)
      |=> ctrl_q == $past(hwdata_in[rxs_pkg::CTRL_W-1:0]))
    else $error("Control write not taken");

  a_reset_ctrl: assert property (
    $past(rst_in) |-> !rx_en && !mii_slow)
    else $error("Reception enabled after reset");

  a_align_in_fcs: assert property (
    hits_q.misalign |-> hits_q.bad_fcs)
    else $error("Alignment error missing from bad-check count");

  a_align_to_fcs: assert property (
    ce_in && frame_ok && frame_in.align_err |=> hits_q.bad_fcs)
    else $error("Misaligned frame not counted as bad-check");

  a_reset_zero: assert property (
    $past(rst_in) |-> bad_fcs_q == CNT_ZERO && misalign_q == CNT_ZERO)
    else $error("Counter not zero after reset");

  a_unmapped_zero: assert property (
    ce_in && addr_phase && !rd_bad_fcs && !rd_misalign
      && !addr_is(haddr_in, rxs_pkg::RX_CTRL_OFF) |=> hrdata_out == 32'h0000_0000)
    else $error("Unmapped access returned data");

  a_align_mode: assert property (
    ce_in && !mii_slow |=> !hits_q.misalign)
    else $error("Alignment counted outside slow MII");

  a_misalign_step: assert property (
    ce_in && hits_q.misalign && !rd_misalign && misalign_q != CNT_TOP
      |=> misalign_q == $past(misalign_q) + CNT_ONE)
    else $error("Misaligned counter did not step by one");

  a_mis_quiet: assert property (
    ce_in && !hits_q.misalign && !rd_misalign |=> misalign_q == $past(misalign_q))
    else $error("Misaligned counter moved without an event");

  a_misalign_clears: assert property (
    ce_in && rd_misalign && !hits_q.misalign |=> misalign_q == CNT_ZERO
      && hrdata_out == widen($past(misalign_q)))
    else $error("Misaligned counter read did not return and clear");

  a_write_no_clear: assert property (
    ce_in && addr_phase && hwrite_in && addr_is(haddr_in, rxs_pkg::BAD_FCS_OFF)
      && !hits_q.bad_fcs |=> bad_fcs_q == $past(bad_fcs_q))
    else $error("Counter write changed the count");

  a_data_stands: assert property (
    ce_in && !addr_phase |=> hrdata_out == $past(hrdata_out))
    else $error("Read data moved outside an address phase");

  a_misalign_sat: assert property (
    misalign_q == CNT_TOP && !rd_misalign |=> misalign_q == CNT_TOP)
    else $error("Saturated misaligned counter moved");

  a_clash_restart: assert property (
    ce_in && rd_bad_fcs && hits_q.bad_fcs |=> bad_fcs_q == CNT_ONE)
    else $error("Event lost on clearing read");

  a_misalign_clash: assert property (
    ce_in && rd_misalign && hits_q.misalign |=> misalign_q == CNT_ONE)
    else $error("Misaligned event lost on clearing read");

  c_bad_frame: cover property (ce_in && hits_q.bad_fcs);
  c_clash: cover property (ce_in && rd_bad_fcs && hits_q.bad_fcs);
  c_misalign: cover property (ce_in && hits_q.misalign);
  c_saturated: cover property (bad_fcs_q == CNT_TOP);
  c_clear_read: cover property (ce_in && rd_bad_fcs && bad_fcs_q != CNT_ZERO);

endmodule : rxs_stat_counters

// ### shared/rxs_pkg.sv
package rxs_pkg;
  // Register byte addresses
  localparam logic [31:0] BAD_FCS_OFF = 32'h0000_4000;
  localparam logic [31:0] MISALIGN_OFF = 32'h0000_4004;
  localparam logic [31:0] RX_CTRL_OFF = 32'h0000_4100;
  // Decode uses word address bits only
  localparam int ADDR_LO = 2;
  localparam int ADDR_HI = 15;
  // Control register fields
  localparam int CTRL_RX_EN_BIT = 0;
  localparam int CTRL_MII_SLOW_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int CTRL_W = 2;
  // Counter reset value and width
  localparam int CNT_W = 32;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX = 32'hffff_ffff;
  // Shortest frame that counts, destination address through check field
  localparam int MIN_FRAME_BYTES = 64;
  localparam int LEN_W = 16;
  // Update latency bound
  localparam int CLK_PERIOD_NS = 25;
  localparam int UPDATE_LIMIT_NS = 1000;
  localparam int UPDATE_LIMIT_CYC = UPDATE_LIMIT_NS / CLK_PERIOD_NS;
  localparam int UPDATE_USED_CYC = 2;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // End-of-frame report from the receive MAC path
  typedef struct packed {
    logic valid;
    logic addr_pass;
    logic stored;
    logic fcs_bad;
    logic align_err;
    logic [LEN_W-1:0] len;
  } rxs_frame_t;

  // Qualified events waiting to hit the counters
  typedef struct packed {
    logic bad_fcs;
    logic misalign;
  } rxs_hits_t;
endpackage : rxs_pkg

// ### verif/rx_error_statistics_counters_bench.sv
`timescale 1ns/1ps
module rx_error_statistics_counters_bench;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  rxs_pkg::rxs_frame_t frm = '0;
  logic [19:0] tbl [6];
  logic [31:0] rd;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  // Short counters so that saturation is reachable in a few frames
  localparam int TB_CNT_W = 4;
  localparam logic [31:0] TB_TOP = (32'h0000_0001 << TB_CNT_W) - 32'h0000_0001;

  always #12.5 core_clk_in = ~core_clk_in;

  rxs_stat_counters #(.MIN_LEN(64), .CNT_W(TB_CNT_W)) uut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .frame_in(frm)
  );

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  // One single AHB transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge core_clk_in);
    hsel <= 1'b1;
    htrans <= rxs_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk_in); while (hready !== 1'b1);
    rdat = hrdata;
    chk({31'h0, hresp}, {31'h0, rxs_pkg::HRESP_OKAY});
  endtask : bus

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask : rd_chk

  // Frame report pulse, then one idle cycle; no gap kept before the next read
  task automatic frame(input logic [19:0] f);
    @(posedge core_clk_in);
    frm <= {1'b1, f};
    @(posedge core_clk_in);
    frm <= '0;
  endtask : frame

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    tbl[0] = {4'b1110, 16'd64};
    tbl[1] = {4'b1110, 16'd63};
    tbl[2] = {4'b0110, 16'd64};
    tbl[3] = {4'b1010, 16'd64};
    tbl[4] = {4'b1100, 16'd1500};
    tbl[5] = {4'b1101, 16'd65};
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0000);
    rd_chk(rxs_pkg::MISALIGN_OFF, 32'h0000_0000);
    rd_chk(rxs_pkg::RX_CTRL_OFF, 32'h0000_0000);
    bus(1'b1, rxs_pkg::BAD_FCS_OFF, 32'hffff_ffff, rd);
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0000);
    rd_chk(32'h0000_4ffc, 32'h0000_0000);
    // Receive still off: a bad frame must leave no trace
    frame(tbl[0]);
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0000);
    bus(1'b1, rxs_pkg::RX_CTRL_OFF, 32'h0000_0001, rd);
    rd_chk(rxs_pkg::RX_CTRL_OFF, 32'h0000_0001);
    for (int i = 0; i < 6; i++) frame(tbl[i]);
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0002);
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0000);
    rd_chk(rxs_pkg::MISALIGN_OFF, 32'h0000_0000);
    bus(1'b1, rxs_pkg::RX_CTRL_OFF, 32'h0000_0003, rd);
    frame(tbl[5]);
    rd_chk(rxs_pkg::MISALIGN_OFF, 32'h0000_0001);
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0001);
    // Two back-to-back frames, then a third whose update meets the read
    @(posedge core_clk_in);
    frm <= {1'b1, tbl[0]};
    @(posedge core_clk_in);
    @(posedge core_clk_in);
    frm <= '0;
    @(posedge core_clk_in);
    frm <= {1'b1, tbl[0]};
    fork
      rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0002);
      begin
        @(posedge core_clk_in);
        frm <= '0;
      end
    join
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0001);
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0000);
    // One frame more than the counter can hold
    for (int i = 0; i < 16; i++) frame(tbl[0]);
    rd_chk(rxs_pkg::BAD_FCS_OFF, TB_TOP);
    rd_chk(rxs_pkg::BAD_FCS_OFF, 32'h0000_0000);
    wrap_up();
  end
endmodule : rx_error_statistics_counters_bench
